// File: hw/dpr_pkg.sv
/*
  constants, field layout and helper functions for the dual-port ram block.
  assumes a single system clock; the two port clocks arrive as enable pulses.
*/
package dpr_pkg;
  // storage shape: 128 physical words of 36 bits, 4 lanes of 9 bits
  localparam int MEM_WORDS = 128;
  localparam int PHYS_W    = 36;
  localparam int CAP_BITS  = 4608;
  localparam int TAP_MAX_W = 36;
  localparam int ADDR_W    = 12;

  // width codes
  localparam logic [3:0] W1       = 4'h0;
  localparam logic [3:0] W16      = 4'h4;
  localparam logic [3:0] W32      = 4'h5;
  localparam logic [3:0] W9       = 4'h6;
  localparam logic [3:0] W18      = 4'h7;
  localparam logic [3:0] W36      = 4'h8;

  // memory modes and clocking schemes
  localparam logic [1:0] MODE_SP  = 2'h0;
  localparam logic [1:0] MODE_SDP = 2'h1;
  localparam logic [1:0] MODE_TDP = 2'h2;
  localparam logic [1:0] CK_IND   = 2'h0;
  localparam logic [1:0] CK_IO    = 2'h1;
  localparam logic [1:0] CK_RW    = 2'h2;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL  = 4'h0;
  localparam logic [3:0] OFS_SHIFT = 4'h4;
  localparam logic [3:0] OFS_STAT  = 4'h8;

  // control field positions
  localparam int CTRL_MODE  = 0;
  localparam int CTRL_CK    = 2;
  localparam int CTRL_BYPA  = 4;
  localparam int CTRL_BYPB  = 5;
  localparam int CTRL_SPLIT = 6;
  localparam int CTRL_SHEN  = 7;
  localparam int CTRL_WA    = 8;
  localparam int CTRL_WB    = 12;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

  // shift geometry field positions
  localparam int SH_W = 0;
  localparam int SH_M = 8;
  localparam int SH_N = 24;
  localparam logic [31:0] SHIFT_RST = 32'h0000_0000;

  // status error bits
  localparam int ERR_CODE  = 0;
  localparam int ERR_TDP   = 1;
  localparam int ERR_MIX   = 2;
  localparam int ERR_SHIFT = 3;
  localparam int ERR_MODE  = 4;

  // data width of a code
  function automatic logic [5:0] code_width(input logic [3:0] c);
    case (c)
      4'h0: code_width = 6'h01;
      4'h1: code_width = 6'h02;
      4'h2: code_width = 6'h04;
      4'h3: code_width = 6'h08;
      4'h4: code_width = 6'h10;
      4'h5: code_width = 6'h20;
      4'h6: code_width = 6'h09;
      4'h7: code_width = 6'h12;
      4'h8: code_width = 6'h24;
      default: code_width = 6'h01;
    endcase
  endfunction

  // address bits used by a code
  function automatic logic [3:0] code_abits(input logic [3:0] c);
    case (c)
      4'h6: code_abits = 4'h9;
      4'h7: code_abits = 4'h8;
      4'h8: code_abits = 4'h7;
      default: code_abits = (c > 4'h5) ? 4'h7 : 4'(4'hC - c);
    endcase
  endfunction

  function automatic logic code_par(input logic [3:0] c);
    code_par = (c >= W9);
  endfunction
endpackage

// File: hw/dpr_ram_top.sv
/*
  configurable dual-port ram block: two user ports, mode/clock/width set by
  software over an avalon-mm slave with waitrequest.
  assumes port clocks come in as one-cycle enables synchronous to mclk and
  that user logic avoids same-address writes from both ports at once.
*/
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module dpr_ram_top import dpr_pkg::*; #(
  parameter int DATA_W = 36,
  parameter int AW     = 12
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              clk_a_en,
  input  wire logic              clk_b_en,
  input  wire logic              clken_a,
  input  wire logic              clken_b,
  input  wire logic              clr_a,
  input  wire logic              clr_b,
  input  wire logic [AW-1:0]     addr_a,
  input  wire logic [AW-1:0]     addr_b,
  input  wire logic [DATA_W-1:0] din_a,
  input  wire logic [DATA_W-1:0] din_b,
  input  wire logic [3:0]        byteena_a,
  input  wire logic [3:0]        byteena_b,
  input  wire logic              wren_a,
  input  wire logic              wren_b,
  input  wire logic              rden_a,
  input  wire logic              rden_b,
  output logic      [DATA_W-1:0] dout_a,
  output logic      [DATA_W-1:0] dout_b
);
  if (DATA_W != PHYS_W || AW != ADDR_W) begin : g_chk
    $error("dpr_ram_top: DATA_W must be 36 and AW must be 12");
  end

  typedef struct packed {
    logic [MEM_WORDS-1:0][PHYS_W-1:0] mem;
    logic [31:0]                      ctrl;
    logic [31:0]                      shift;
    logic [4:0]                       err;
    logic                             wait_r;
    logic [31:0]                      rdata;
    logic [1:0][AW-1:0]               addr;
    logic [1:0][PHYS_W-1:0]           din;
    logic [1:0][3:0]                  be;
    logic [1:0]                       we;
    logic [1:0]                       re;
    logic [1:0]                       go;
    logic [1:0][PHYS_W-1:0]           hold;
    logic [1:0][PHYS_W-1:0]           dout;
  } dpr_state_s;

  dpr_state_s s_r;
  dpr_state_s s_nxt;

  // port inputs gathered by index
  logic [1:0][AW-1:0]     in_addr;
  logic [1:0][PHYS_W-1:0] in_din;
  logic [1:0][3:0]        in_be;
  logic [1:0]             in_we;
  logic [1:0]             in_re;
  assign in_addr = {addr_b, addr_a};
  assign in_din  = {din_b, din_a};
  assign in_be   = {byteena_b, byteena_a};
  assign in_we   = {wren_b, wren_a};
  assign in_re   = {rden_b, rden_a};

  // decoded configuration
  logic [1:0]       mode;
  logic [1:0]       ckm;
  logic [1:0][3:0]  wcode;
  logic [1:0]       byp;
  logic             split;
  logic [5:0]       sh_w;
  logic [12:0]      sh_m;
  logic [5:0]       sh_n;
  logic [24:0]      sh_bits;
  logic [11:0]      sh_outs;
  logic [4:0]       err_now;
  logic             req;
  assign mode    = s_r.ctrl[CTRL_MODE +: 2];
  assign ckm     = s_r.ctrl[CTRL_CK +: 2];
  assign wcode   = {s_r.ctrl[CTRL_WB +: 4], s_r.ctrl[CTRL_WA +: 4]};
  assign byp     = {s_r.ctrl[CTRL_BYPB], s_r.ctrl[CTRL_BYPA]};
  assign split   = s_r.ctrl[CTRL_SPLIT];
  assign sh_w    = s_r.shift[SH_W +: 6];
  assign sh_m    = s_r.shift[SH_M +: 13];
  assign sh_n    = s_r.shift[SH_N +: 6];
  assign sh_bits = 25'(sh_w * sh_m * sh_n);
  assign sh_outs = 12'(sh_w * sh_n);
  assign req     = avs_read | avs_write;

  // legality of the shape set by software
  always_comb begin
    err_now = 5'h00;
    err_now[ERR_CODE] = (wcode[0] > W36) || (wcode[1] > W36);
    err_now[ERR_TDP]  = (mode == MODE_TDP) &&
                        (wcode[0] == W32 || wcode[0] == W36 ||
                         wcode[1] == W32 || wcode[1] == W36);
    err_now[ERR_MIX]  = (mode != MODE_SP) &&
                        (code_par(wcode[0]) != code_par(wcode[1]));
    err_now[ERR_SHIFT] = s_r.ctrl[CTRL_SHEN] &&
                         (sh_bits > 25'(CAP_BITS) || sh_outs > 12'(TAP_MAX_W));
    err_now[ERR_MODE] = (mode == 2'h3) || (ckm == 2'h3);
  end

  // per-port clock enables and clears from the clocking scheme
  logic [1:0] in_en;
  logic [1:0] out_en;
  logic [1:0] in_clr;
  logic [1:0] out_clr;
  logic [1:0] we_ok;
  logic [1:0] re_ok;
  always_comb begin
    if (ckm == CK_IO) begin
      in_en   = {2{clk_a_en & clken_a}};
      out_en  = {2{clk_b_en & clken_b}};
      in_clr  = {2{clr_a}};
      out_clr = {2{clr_b}};
    end else begin
      // independent and read/write: side a on clock a, side b on clock b
      in_en   = {clk_b_en & clken_b, clk_a_en & clken_a};
      out_en  = in_en;
      in_clr  = {clr_b, clr_a};
      out_clr = {clr_b, clr_a};
    end
    // which operations each port may carry out in the current mode
    case (mode)
      MODE_SP: begin
        we_ok = {split, 1'b1};
        re_ok = {split, 1'b1};
      end
      MODE_SDP: begin
        we_ok = 2'b01;
        re_ok = 2'b10;
      end
      default: begin
        we_ok = 2'b11;
        re_ok = 2'b11;
      end
    endcase
  end

  // next-state logic: bus slave, port registers and the array
  always_comb begin
    logic [AW-1:0]     kk;
    logic [11:0]       lin;
    logic [6:0]        wd;
    logic [5:0]        st;
    logic [5:0]        l;
    logic [5:0]        pos;
    logic [1:0]        lane;
    logic [3:0]        be_eff;
    logic              par;
    logic [5:0]        w;
    logic [PHYS_W-1:0] rv;
    kk     = '0;
    lin    = '0;
    wd     = '0;
    st     = '0;
    l      = '0;
    pos    = '0;
    lane   = '0;
    be_eff = '0;
    par    = 1'b0;
    w      = '0;
    rv     = '0;
    s_nxt  = s_r;

    // avalon slave: answer one cycle after the request appears
    s_nxt.wait_r = ~(req & s_r.wait_r);
    if (avs_read && s_r.wait_r) begin
      if (avs_address == OFS_CTRL) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (avs_address == OFS_SHIFT) begin
        s_nxt.rdata = s_r.shift;
      end else if (avs_address == OFS_STAT) begin
        s_nxt.rdata = {27'h0000000, s_r.err};
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end
    if (avs_write && !s_r.wait_r) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          if (avs_address == OFS_CTRL) begin
            s_nxt.ctrl[b*8 +: 8] = avs_writedata[b*8 +: 8];
          end else if (avs_address == OFS_SHIFT) begin
            s_nxt.shift[b*8 +: 8] = avs_writedata[b*8 +: 8];
          end
        end
      end
    end
    s_nxt.err = err_now;

    for (int p = 0; p < 2; p++) begin
      // locate the addressed slice of the store
      w   = code_width(wcode[p]);
      par = code_par(wcode[p]);
      kk  = s_r.addr[p] & (12'hFFF >> (4'hC - code_abits(wcode[p])));
      if (!par) begin
        lin = 12'(kk << wcode[p][2:0]);
        wd  = lin[11:5];
        st  = {1'b0, lin[4:0]};
      end else if (wcode[p] == W9) begin
        wd  = kk[8:2];
        st  = 6'({kk[1:0], 3'b000}) + 6'(kk[1:0]);
      end else if (wcode[p] == W18) begin
        wd  = kk[7:1];
        st  = kk[0] ? 6'h12 : 6'h00;
      end else begin
        wd  = kk[6:0];
        st  = 6'h00;
      end
      if (mode == MODE_SP && split) begin
        wd[6] = p[0];
      end
      be_eff = (wcode[p] == W16 || wcode[p] == W32 ||
                wcode[p] == W18 || wcode[p] == W36) ? s_r.be[p] : 4'hF;
      rv = '0;
      for (int i = 0; i < PHYS_W; i++) begin
        l    = 6'(st + 6'(i));
        // plain widths skip the ninth bit of each lane
        pos  = par ? l : 6'({l[4:3], 3'b000}) + 6'(l[4:3]) + 6'(l[2:0]);
        lane = par ? 2'(i / 9) : 2'(i >> 3);
        if (6'(i) < w) begin
          rv[i] = s_r.mem[wd][pos];
          // port b is applied last if both hit one location
          if (s_r.go[p] && s_r.we[p] && we_ok[p] && err_now == 5'h00 &&
              be_eff[lane]) begin
            s_nxt.mem[wd][pos] = s_r.din[p][i];
          end
        end
      end

      // input registers always in the path
      s_nxt.go[p] = 1'b0;
      if (in_clr[p]) begin
        s_nxt.addr[p] = '0;
        s_nxt.din[p]  = '0;
        s_nxt.be[p]   = '0;
        s_nxt.we[p]   = 1'b0;
        if (!(mode == MODE_SDP && p == 1)) begin
          s_nxt.re[p] = 1'b0;
        end
      end else if (in_en[p]) begin
        s_nxt.addr[p] = in_addr[p];
        s_nxt.din[p]  = in_din[p];
        s_nxt.be[p]   = in_be[p];
        s_nxt.we[p]   = in_we[p];
        s_nxt.re[p]   = in_re[p];
        s_nxt.go[p]   = 1'b1;
      end

      // output stage: registered or bypassed
      if (out_clr[p]) begin
        s_nxt.hold[p] = '0;
        s_nxt.dout[p] = '0;
      end else begin
        if (s_r.go[p] && s_r.re[p] && re_ok[p]) begin
          s_nxt.hold[p] = rv;
          if (byp[p]) begin
            s_nxt.dout[p] = rv;
          end
        end
        if (!byp[p] && out_en[p]) begin
          s_nxt.dout[p] = s_r.hold[p];
        end
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r        <= '0;
      s_r.ctrl   <= CTRL_RST;
      s_r.shift  <= SHIFT_RST;
      s_r.wait_r <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.wait_r;
  assign dout_a          = s_r.dout[0];
  assign dout_b          = s_r.dout[1];

  // checks on the block's own behaviour
  a_wait_answer: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (req && s_r.wait_r) |=> !s_r.wait_r ##1 s_r.wait_r)
    else $error("bus answer not one cycle after request");

  a_tdp_wide: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (mode == MODE_TDP && (wcode[0] == W32 || wcode[1] == W36)) |=> s_r.err[ERR_TDP])
    else $error("wide shape in true dual-port not flagged");

  a_mix_flag: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (mode == MODE_SDP && wcode[0] == W9 && wcode[1] == W16) |=> s_r.err[ERR_MIX])
    else $error("parity and plain widths mixed without flag");

  a_shift_cap: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (s_r.ctrl[CTRL_SHEN] && sh_bits > 25'(CAP_BITS)) |=> s_r.err[ERR_SHIFT])
    else $error("oversized shift geometry not flagged");

  a_mask_none: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (s_r.go == 2'b01 && s_r.we[0] && s_r.be[0] == 4'h0 && wcode[0] == W36)
    |=> $stable(s_r.mem))
    else $error("write with all lanes off changed the array");

  a_capture_go: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (in_en[0] && !in_clr[0]) |=> s_r.go[0] && s_r.addr[0] == $past(in_addr[0]))
    else $error("port a input not captured on its enable");

  a_bypass_out: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (s_r.go[1] && s_r.re[1] && re_ok[1] && byp[1] && !out_clr[1])
    |=> (dout_b == s_r.hold[1] && s_r.dout[1] == s_r.hold[1]))
    else $error("bypassed output did not follow the read");

  a_rden_noclr: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (mode == MODE_SDP && in_clr[1]) |=> s_r.re[1] == $past(s_r.re[1]))
    else $error("read enable register was cleared in simple dual-port");

  a_clr_input: assert property (
    @(posedge mclk) disable iff (!rst_n)
    in_clr[0] |=> (s_r.addr[0] == '0 && !s_r.we[0] && !s_r.go[0]))
    else $error("port a input registers not cleared");

  a_io_outclk: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ckm == CK_IO && !byp[0] && !clk_b_en && !clr_b) |=> $stable(dout_a))
    else $error("io mode output moved without the output clock");
endmodule

// File: test/dpr_fab_model.sv
/*
  fabric-side user logic driving both ram ports with one-cycle enable pulses.
  assumes mclk is the system clock and that the bench calls one task at a time.
*/
`timescale 1ns/100ps
module dpr_fab_model import dpr_pkg::*; (
  input  wire logic        mclk,
  output logic             clk_a_en,
  output logic             clk_b_en,
  output logic             clken_a,
  output logic             clken_b,
  output logic             clr_a,
  output logic             clr_b,
  output logic [11:0]      addr_a,
  output logic [11:0]      addr_b,
  output logic [35:0]      din_a,
  output logic [35:0]      din_b,
  output logic [3:0]       byteena_a,
  output logic [3:0]       byteena_b,
  output logic             wren_a,
  output logic             wren_b,
  output logic             rden_a,
  output logic             rden_b
);
  // idle levels at time zero
  initial begin
    {clk_a_en, clk_b_en, clr_a, clr_b, wren_a, wren_b, rden_a, rden_b} = 8'h00;
    {clken_a, clken_b} = 2'h3;
    {addr_a, addr_b} = 24'h000000;
    {din_a, din_b} = '0;
    {byteena_a, byteena_b} = 8'hFF;
  end

  // one access on port p: k 0 idle pulse, 1 write, 2 read, 3 clear
  // only one port moves per call, so both ports never hit one word at once
  task automatic op(input bit p, input logic [1:0] k, input logic [11:0] a,
                    input logic [35:0] d, input logic [3:0] be);
    logic [3:0] c;
    c = {k != 2'h3, k == 2'h3, k == 2'h1, k == 2'h2};
    // request stands for exactly one port clock pulse
    @(posedge mclk);
    if (p) {clk_b_en, clr_b, wren_b, rden_b, addr_b, din_b, byteena_b} <= {c, a, d, be};
    else {clk_a_en, clr_a, wren_a, rden_a, addr_a, din_a, byteena_a} <= {c, a, d, be};
    // released address and data lines show inverted garbage, never the last value; strobes drop to zero and byteena keeps its value
    @(posedge mclk);
    if (p) {clk_b_en, clr_b, wren_b, rden_b, addr_b, din_b} <= {4'h0, ~a, ~d};
    else {clk_a_en, clr_a, wren_a, rden_a, addr_a, din_a} <= {4'h0, ~a, ~d};
  endtask

  // per-port clock enable level
  task automatic ce(input bit p, input bit v);
    @(posedge mclk);
    if (p) clken_b <= v;
    else clken_a <= v;
  endtask
endmodule

// File: test/test_configurable_dual_port_block_ram.sv
/*
  self-checking bench for the dual-port ram block: avalon register tasks,
  port accesses through the fabric model, directed tests with expectations.
  assumes the package, the design and the fabric model are compiled first.
*/
`timescale 1ns/100ps
module test_configurable_dual_port_block_ram import dpr_pkg::*;;
  logic        mclk = 1'b0;
  logic        rst_n;
  logic [3:0]  avs_address, avs_byteenable, byteena_a, byteena_b;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        clk_a_en, clk_b_en, clken_a, clken_b, clr_a, clr_b;
  logic        wren_a, wren_b, rden_a, rden_b;
  logic [11:0] addr_a, addr_b;
  logic [35:0] din_a, din_b, dout_a, dout_b, d;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // 10 MHz system clock
  always #50 mclk = ~mclk;

  dpr_ram_top #(.DATA_W(36), .AW(12)) dut (.mclk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .clk_a_en, .clk_b_en, .clken_a, .clken_b, .clr_a, .clr_b, .addr_a, .addr_b,
    .din_a, .din_b, .byteena_a, .byteena_b, .wren_a, .wren_b, .rden_a, .rden_b,
    .dout_a, .dout_b);

  dpr_fab_model fab (.mclk, .clk_a_en, .clk_b_en, .clken_a, .clken_b, .clr_a, .clr_b,
    .addr_a, .addr_b, .din_a, .din_b, .byteena_a, .byteena_b, .wren_a, .wren_b,
    .rden_a, .rden_b);

  // compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and stop
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] dw,
                     output logic [31:0] r);
    @(posedge mclk);
    {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, dw};
    // waitrequest looked at on rising edges only; the hang guard ends a stuck wait
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    // read data taken and request dropped at the edge that saw the answer
    r = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
  endtask

  // register read with expectation
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, rd);
    check({4'h0, rd}, {4'h0, e});
  endtask

  // register write, then status expectation
  task automatic cfg(input logic [3:0] a, input logic [31:0] v, input logic [31:0] st);
    bus(1'b1, a, v, rd);
    rchk(OFS_STAT, st);
  endtask

  // port read; with bypass dout settles one edge after capture
  task automatic prd(input bit p, input logic [11:0] a, input logic [35:0] e);
    fab.op(p, 2'h2, a, 36'h0, 4'hF);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check(p ? dout_b : dout_a, e);
  endtask

  // lone output pulse (k 0) or clear (k 3), then look at dout
  task automatic pchk(input bit p, input logic [1:0] k, input logic [35:0] e);
    fab.op(p, k, 12'h000, 36'h0, 4'hF);
    @(negedge mclk);
    check(p ? dout_b : dout_a, e);
  endtask

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    {avs_read, avs_write} = 2'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    rst_n = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check(dout_a | dout_b, 36'h0);
    rchk(OFS_CTRL, CTRL_RST);
    rchk(OFS_SHIFT, SHIFT_RST);
    rchk(4'hC, 32'h0000_0000);
    cfg(OFS_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    // every width code in true and simple dual-port
    for (int c = 0; c < 9; c++) begin
      cfg(OFS_CTRL, {16'h0000, 4'(c), 4'(c), 8'h02}, (c == 5 || c == 8) ? 32'h2 : 32'h0);
      cfg(OFS_CTRL, {16'h0000, 4'(c), 4'(c), 8'h01}, 32'h0000_0000);
    end
    cfg(OFS_CTRL, 32'h0000_6501, 32'h0000_0004);
    cfg(OFS_CTRL, 32'h0000_8601, 32'h0000_0000);
    cfg(OFS_CTRL, 32'h0000_0401, 32'h0000_0000);
    cfg(OFS_CTRL, 32'h0000_3801, 32'h0000_0004);
    cfg(OFS_CTRL, 32'h0000_9901, 32'h0000_0001);
    cfg(OFS_CTRL, 32'h0000_0003, 32'h0000_0010);
    cfg(OFS_CTRL, 32'h0000_0080, 32'h0000_0000);
    cfg(OFS_SHIFT, 32'h0102_4008, 32'h0000_0000);
    cfg(OFS_SHIFT, 32'h0102_4108, 32'h0000_0008);
    cfg(OFS_SHIFT, 32'h0100_8024, 32'h0000_0000);
    cfg(OFS_SHIFT, 32'h0500_0109, 32'h0000_0008);
    // simple dual-port, A x36 writes with 9-bit lanes, B x9 reads
    cfg(OFS_CTRL, 32'h0000_6839, 32'h0000_0000);
    d = 36'hA_BCDE_F012;
    fab.op(1'b0, 2'h1, 12'h003, d, 4'hF);
    fab.op(1'b0, 2'h1, 12'h003, 36'h0, 4'h5);
    fab.op(1'b0, 2'h1, 12'h003, 36'h0, 4'h0);
    d = d & ~{9'h000, 9'h1FF, 9'h000, 9'h1FF};
    for (int k = 0; k < 4; k++) prd(1'b1, 12'(12 + k), {27'h0, d[9*k +: 9]});
    // true dual-port, A x16 with 8-bit lanes, B x4
    cfg(OFS_CTRL, 32'h0000_2432, 32'h0000_0000);
    fab.op(1'b0, 2'h1, 12'h005, 36'h0_0000_FFFF, 4'hF);
    fab.op(1'b0, 2'h1, 12'h005, 36'h0, 4'h2);
    fab.op(1'b1, 2'h1, 12'h000, 36'h7, 4'hF);
    for (int k = 0; k < 4; k++) prd(1'b1, 12'(20 + k), (k < 2) ? 36'hF : 36'h0);
    prd(1'b0, 12'h005, 36'h0_0000_00FF);
    prd(1'b0, 12'h000, 36'h0_0000_0007);
    // output registers in the path: dout waits for the next port pulse
    cfg(OFS_CTRL, 32'h0000_2402, 32'h0000_0000);
    fab.op(1'b1, 2'h2, 12'h016, 36'h0, 4'hF);
    pchk(1'b1, 2'h0, 36'h0);
    prd(1'b1, 12'h014, 36'h0);
    pchk(1'b1, 2'h0, 36'hF);
    fab.op(1'b0, 2'h2, 12'h005, 36'h0, 4'hF);
    pchk(1'b0, 2'h0, 36'h0_0000_00FF);
    // clear of port B leaves port A alone
    pchk(1'b1, 2'h3, 36'h0);
    check(dout_a, 36'h0_0000_00FF);
    // clock enable low on A blocks its write
    fab.ce(1'b0, 1'b0);
    fab.op(1'b0, 2'h1, 12'h005, 36'h0_0000_FFFF, 4'hF);
    fab.ce(1'b0, 1'b1);
    fab.op(1'b0, 2'h2, 12'h005, 36'h0, 4'hF);
    pchk(1'b0, 2'h0, 36'h0_0000_00FF);
    // io clock mode, true dual-port: inputs on clock a, outputs on clock b
    cfg(OFS_CTRL, 32'h0000_4406, 32'h0000_0000);
    fab.op(1'b0, 2'h2, 12'h000, 36'h0, 4'hF);
    pchk(1'b0, 2'h0, 36'h0_0000_00FF);
    fab.op(1'b1, 2'h0, 12'h000, 36'h0, 4'hF);
    @(negedge mclk);
    check(dout_a, 36'h0_0000_0007);
    pchk(1'b0, 2'h3, 36'h0_0000_0007);
    pchk(1'b1, 2'h3, 36'h0);
    check(dout_a, 36'h0);
    // io clock mode, simple dual-port: mixed widths flagged, input clear
    cfg(OFS_CTRL, 32'h0000_4605, 32'h0000_0004);
    pchk(1'b0, 2'h3, 36'h0);
    // single-port split: port a low half, port b high half, x8 ignores mask
    cfg(OFS_CTRL, 32'h0000_3470, 32'h0000_0000);
    fab.op(1'b0, 2'h1, 12'h000, 36'h0_0000_1234, 4'hF);
    fab.op(1'b1, 2'h1, 12'h000, 36'h0_0000_0078, 4'h0);
    prd(1'b0, 12'h000, 36'h0_0000_1234);
    prd(1'b1, 12'h000, 36'h0_0000_0078);
    end_of_test();
  end
endmodule
